// *** logic/flash_host_cfg.svh ***
// Constants for the parallel boot-flash host controller.
// Assumes inclusion by the package, the controller, the checker, the flash model and the testbench.
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH
// Command codes written to the device command decoder.
`define CMD_READ_ARRAY   8'hFF
`define CMD_READ_ID      8'h90
`define CMD_READ_STATUS  8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_PROGRAM      8'h40
`define CMD_ERASE_SETUP  8'h20
`define CMD_ERASE_OK     8'hD0
// Status register bit positions.
`define SR_READY_BIT     7
`define SR_ERASE_ERR_BIT 5
`define SR_PROG_ERR_BIT  4
`define SR_SUPPLY_ERR_BIT 3
// Own register offsets (byte addresses).
`define REG_CTRL   12'h000
`define REG_ADDR   12'h004
`define REG_WDATA  12'h008
`define REG_STATUS 12'h00C
`define REG_RDATA  12'h010
// Control field positions.
`define CTRL_GO_BIT    0
`define CTRL_OP_LSB    1
`define CTRL_PINRST_BIT 4
// Bus timing: phase length and reset pulse in ns.
`define T_PHASE_NS 60
`define T_RESET_NS 100
`define CLK_NS     20
`define PHASE_CYC  ((`T_PHASE_NS + `CLK_NS - 1) / `CLK_NS)
`define RESET_CYC  ((`T_RESET_NS + `CLK_NS - 1) / `CLK_NS)
// AXI response codes.
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// *** logic/flash_host_pkg.sv ***
// Types for the parallel boot-flash host controller.
// Assumes the constants header is on the include path.
`include "flash_host_cfg.svh"
package flash_host_pkg;
  // Operations software can request.
  typedef enum logic [2:0] {
    OP_READ_ARRAY = 3'h0, OP_READ_ID = 3'h1, OP_READ_STATUS = 3'h2, OP_CLEAR = 3'h3,
    OP_PROGRAM = 3'h4, OP_ERASE = 3'h5, OP_POLL = 3'h6, OP_RESET = 3'h7
  } op_t;
  // Pins toward the flash device.
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        reset_powerdown_n;
    logic [19:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
  } flash_pins_t;
  // AXI4-Lite request and answer channels.
  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;
endpackage

// *** logic/flash_host.sv ***
// Host controller that drives an asynchronous parallel boot flash over its pins.
// Assumes software reaches it over AXI4-Lite and the flash pins settle within one phase.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
// Notes on behaviour
// - Host toggles select between status polls to see completion.
// - Program is setup 40H then address and data write.
// - Erase is 20H then D0H at any block address.
// - Host raises reset level or write-protect to alter boot block.
// - Command writes use select and strobe low, gate high.
module flash_host #(
  parameter int ADDR_W = 20,
  parameter int PHASE  = `PHASE_CYC,
  parameter int RSTLEN = `RESET_CYC
) (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire flash_host_pkg::axi_req_t axi_req,
  output flash_host_pkg::axi_rsp_t    axi_rsp,
  output flash_host_pkg::flash_pins_t pins,
  input  wire logic [15:0]            dq_in,
  output logic                        write_protect
);
  import flash_host_pkg::*;

  // A write phase needs at least one low-strobe cycle and one cycle with the strobe high before select rises.
  if (PHASE < 2 || PHASE > 255 || RSTLEN < 1 || RSTLEN > 255 || ADDR_W != 20) begin : gen_param_check
    $error("flash_host: unsupported parameter values");
  end

  // =====================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0, ST_W1 = 3'h1, ST_GAP = 3'h2, ST_W2 = 3'h3,
    ST_RD    = 3'h4, ST_RST = 3'h5, ST_DONE = 3'h6
  } seq_t;

  seq_t        state_r, state_nxt;
  logic [7:0]  cnt_r;
  op_t         op_r;
  logic [19:0] addr_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic        busy_r;
  logic        pinrst_r;
  flash_pins_t pins_r;
  axi_rsp_t    rsp_r;
  logic        aw_got_r, w_got_r;
  logic [11:0] awaddr_r;
  logic [31:0] wbuf_r;

  // =====================================================================
  // Register write path: address and data may arrive in either order.
  wire        wr_fire  = aw_got_r && w_got_r && !rsp_r.bvalid;
  wire        hit_ctrl = (awaddr_r == `REG_CTRL);
  wire        hit_addr = (awaddr_r == `REG_ADDR);
  wire        hit_wdat = (awaddr_r == `REG_WDATA);
  wire        wr_ok    = hit_ctrl || hit_addr || hit_wdat;
  wire        go       = wr_fire && hit_ctrl && wbuf_r[`CTRL_GO_BIT] && !busy_r;
  wire op_t   go_op    = op_t'(wbuf_r[`CTRL_OP_LSB +: 3]);
  wire        rd_fire  = axi_req.arvalid && !rsp_r.rvalid;
  wire [31:0] stat_word = {29'h0, pinrst_r, state_r == ST_DONE, busy_r};
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    if (axi_req.araddr == `REG_CTRL) begin
      rd_val = {27'h0, pinrst_r, op_r, 1'b0};
    end else if (axi_req.araddr == `REG_ADDR) begin
      rd_val = {12'h0, addr_r};
    end else if (axi_req.araddr == `REG_WDATA) begin
      rd_val = {16'h0, wdata_r};
    end else if (axi_req.araddr == `REG_STATUS) begin
      rd_val = stat_word;
    end else if (axi_req.araddr == `REG_RDATA) begin
      rd_val = {16'h0, rdata_r};
    end else begin
      rd_val = 32'h0;
      rd_ok  = 1'b0;
    end
  end

  // Bus handshakes and register storage.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsp_r    <= '0;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 12'h000;
      wbuf_r   <= 32'h0;
      addr_r   <= 20'h00000;
      wdata_r  <= 16'hFFFF;
      pinrst_r <= 1'b0;
    end else begin
      rsp_r.awready <= axi_req.awvalid && !aw_got_r && !rsp_r.awready;
      rsp_r.wready  <= axi_req.wvalid && !w_got_r && !rsp_r.wready;
      if (axi_req.awvalid && rsp_r.awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= axi_req.awaddr;
      end
      if (axi_req.wvalid && rsp_r.wready) begin
        w_got_r <= 1'b1;
        wbuf_r  <= axi_req.wdata;
      end
      if (wr_fire) begin
        rsp_r.bvalid <= 1'b1;
        rsp_r.bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        if (hit_addr) addr_r <= wbuf_r[19:0];
        if (hit_wdat) wdata_r <= wbuf_r[15:0];
        if (hit_ctrl) pinrst_r <= wbuf_r[`CTRL_PINRST_BIT];
      end else if (rsp_r.bvalid && axi_req.bready) begin
        rsp_r.bvalid <= 1'b0;
      end
      rsp_r.arready <= rd_fire && !rsp_r.arready;
      if (axi_req.arvalid && rsp_r.arready) begin
        rsp_r.rvalid <= 1'b1;
        rsp_r.rdata  <= rd_val;
        rsp_r.rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rsp_r.rvalid && axi_req.rready) begin
        rsp_r.rvalid <= 1'b0;
      end
    end
  end

  // =====================================================================
  // Command bytes per operation: first write, second write.
  wire two_writes = (op_r == OP_PROGRAM) || (op_r == OP_ERASE);
  // The new operation steers the first phase at the same edge that accepts it.
  wire op_t   cur_op  = go ? go_op : op_r;
  wire        cur_two = (cur_op == OP_PROGRAM) || (cur_op == OP_ERASE);
  logic [7:0] first_cmd;
  always_comb begin
    case (cur_op)
      OP_READ_ARRAY:  first_cmd = `CMD_READ_ARRAY;
      OP_READ_ID:     first_cmd = `CMD_READ_ID;
      OP_READ_STATUS: first_cmd = `CMD_READ_STATUS;
      OP_CLEAR:       first_cmd = `CMD_CLEAR_STATUS;
      OP_PROGRAM:     first_cmd = `CMD_PROGRAM;
      OP_ERASE:       first_cmd = `CMD_ERASE_SETUP;
      default:        first_cmd = `CMD_READ_STATUS;
    endcase
  end
  // Program carries the data word; erase carries the confirm code.
  wire [15:0] second_data = (op_r == OP_PROGRAM) ? wdata_r : {8'h00, `CMD_ERASE_OK};
  wire phase_end = (cnt_r == 8'(PHASE - 1));
  // Count of the coming cycle; the strobe rises in the last cycle of a write phase.
  wire [7:0] cnt_nxt = (state_nxt != state_r) ? 8'h00 : cnt_r + 8'h01;
  wire       we_last = (cnt_nxt == 8'(PHASE - 1));

  // Sequencer next state.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (go) state_nxt = (go_op == OP_RESET) ? ST_RST : (go_op == OP_POLL) ? ST_RD : ST_W1;
      ST_W1:   if (phase_end) state_nxt = ST_GAP;
      ST_GAP:  if (phase_end) state_nxt = two_writes ? ST_W2 : ST_RD;
      ST_W2:   if (phase_end) state_nxt = ST_DONE;
      ST_RD:   if (phase_end) state_nxt = ST_DONE;
      ST_RST:  if (cnt_r == 8'(RSTLEN - 1)) state_nxt = ST_DONE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Pin drive; each read is a fresh select so a new status snapshot is taken.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ST_IDLE;
      cnt_r   <= 8'h00;
      op_r    <= OP_READ_ARRAY;
      busy_r  <= 1'b0;
      rdata_r <= 16'h0000;
      pins_r  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_powerdown_n: 1'b0,
                   addr: 20'h00000, dq_out: 16'h0000, dq_oe: 1'b0};
      write_protect <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      pins_r.reset_powerdown_n <= (state_nxt != ST_RST) && !pinrst_r;
      write_protect <= cur_two && (go || busy_r);
      if (go) begin
        op_r   <= go_op;
        busy_r <= 1'b1;
      end else if (state_r == ST_DONE) begin
        busy_r <= 1'b0;
      end
      // Writes: select and strobe low, gate high; strobe rises before select.
      pins_r.we_n  <= !((state_nxt == ST_W1) || (state_nxt == ST_W2)) || we_last;
      pins_r.ce_n  <= !((state_nxt == ST_W1) || (state_nxt == ST_W2) || (state_nxt == ST_RD));
      pins_r.oe_n  <= (state_nxt != ST_RD);
      pins_r.dq_oe <= (state_nxt == ST_W1) || (state_nxt == ST_W2);
      pins_r.addr  <= addr_r;
      pins_r.dq_out <= (state_nxt == ST_W2) ? second_data : {8'hFF, first_cmd};
      if (state_r == ST_RD && phase_end) begin
        rdata_r <= dq_in;
      end
    end
  end

  assign pins    = pins_r;
  assign axi_rsp = rsp_r;
endmodule

// *** testbench/flash_host_sva.sv ***
// Checker on the ports of the flash host controller.
// Assumes it is bound onto flash_host, one clock and reset.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_host_sva #(parameter int PHASE = 3) (
  input wire logic                        clk_sys,
  input wire logic                        srst,
  input wire flash_host_pkg::axi_req_t    axi_req,
  input wire flash_host_pkg::axi_rsp_t    axi_rsp,
  input wire flash_host_pkg::flash_pins_t pins,
  input wire logic [15:0]                 dq_in,
  input wire logic                        write_protect
);
  import flash_host_pkg::*;
  localparam int LIM = 6 * PHASE + 2;
  // ==========================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // An erase setup write ends, then its confirm write follows.
  sequence erase_setup;
    !pins.we_n && pins.dq_out[7:0] == `CMD_ERASE_SETUP ##1 pins.we_n;
  endsequence
  sequence erase_confirm;
    !pins.we_n && pins.dq_out[7:0] == `CMD_ERASE_OK;
  endsequence
  AST_WRITE_GATE: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n && pins.dq_oe)
    else $error("write strobe low outside a gated write");
  AST_BUS_FREE: assert property (!pins.oe_n |-> !pins.dq_oe && pins.we_n)
    else $error("host drives data while output gate is low");
  AST_WE_FIRST: assert property ($rose(pins.we_n) |-> !pins.ce_n ##1 pins.ce_n)
    else $error("write strobe did not rise one cycle before select");
  AST_PROTECT: assert property (!pins.we_n && pins.dq_out[7:0] == `CMD_PROGRAM |-> write_protect)
    else $error("program setup without write protect high");
  AST_ERASE_CONFIRM: assert property (erase_setup |-> ##[1:LIM] erase_confirm)
    else $error("erase setup not followed by confirm");
  AST_POLL_TOGGLE: assert property ($fell(pins.oe_n) |-> ##[1:LIM] (pins.oe_n || pins.ce_n))
    else $error("read cycle never ended");
  AST_RESET_PINS: assert property (disable iff (1'b0) srst |=>
    pins.ce_n && pins.oe_n && pins.we_n && !pins.reset_powerdown_n && !pins.dq_oe)
    else $error("pins not idle in reset");
  AST_RD_LATENCY: assert property (axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
endmodule
bind flash_host flash_host_sva #(.PHASE(PHASE)) u_sva (.clk_sys(clk_sys), .srst(srst), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .pins(pins), .dq_in(dq_in), .write_protect(write_protect));

// *** testbench/boot_flash_model.sv ***
// Behavioural boot flash device answering the host pins.
// Assumes the bench clock only paces the internal state machine.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module boot_flash_model #(
  parameter logic [15:0] MFR_CODE = 16'h00A7, // Arbitrary value.
  parameter logic [15:0] DEV_CODE = 16'h3C5E, // Arbitrary value.
  parameter bit          BYTE_WIDE = 1'b0
) (
  input wire logic                        clk_sys,
  input wire flash_host_pkg::flash_pins_t pins,
  input wire logic                        vpp_ok,
  output logic [15:0]                     dq_in
);
  import flash_host_pkg::*;
  logic [15:0] mem [16];
  logic [15:0] ld;
  logic [7:0]  sr, snap;
  logic [3:0]  la;
  logic [1:0]  mode;
  logic        pend_p, pend_e, flip, wc_q;
  int          busy;
  // ==========================================
  // Read path: undriven lines toggle every cycle.
  wire drive = pins.reset_powerdown_n && !pins.ce_n && !pins.oe_n && pins.we_n;
  wire [15:0] q = mode == 2'd0 ? mem[pins.addr[3:0]] :
    mode == 2'd1 ? (pins.addr[0] ? DEV_CODE : MFR_CODE) : {8'h00, snap};
  wire [15:0] float_pat = {8{flip, !flip}};
  // Byte-wide parts leave lines eight up floating on identifier and status reads.
  wire [15:0] q_out = (BYTE_WIDE && mode != 2'd0) ? {float_pat[15:8], q[7:0]} : q;
  assign dq_in = pins.dq_oe ? pins.dq_out : drive ? q_out : float_pat;
  // Power-up state.
  initial begin
    {mode, pend_p, pend_e, flip, wc_q, busy, snap, sr} = {5'h00, 1'b1, 32'h0, 8'h00, 8'h80};
    foreach (mem[i]) mem[i] = 16'hFFFF;
  end
  // Status snapshot on the last falling select or gate.
  always @(negedge pins.oe_n or negedge pins.ce_n) if (!pins.oe_n && !pins.ce_n) snap = sr;
  // Command decoder and write state machine.
  always @(posedge clk_sys) begin
    flip = !flip;
    if (busy > 0) busy--;
    if (busy == 1) sr[7] = 1'b1;
    if (!pins.we_n && !pins.ce_n) {la, ld} = {pins.addr[3:0], pins.dq_out};
    if (!pins.reset_powerdown_n) {mode, pend_p, pend_e, busy, sr} = {4'h0, 32'h0, 8'h80};
    else if (!wc_q && (pins.we_n || pins.ce_n) && busy == 0) begin
      if (pend_p || pend_e) begin
        if (!vpp_ok) sr[3] = 1'b1;
        if (pend_p && vpp_ok) mem[la] = mem[la] & ld;
        if (pend_p && !vpp_ok) sr[4] = 1'b1;
        if (pend_e && vpp_ok && ld[7:0] == `CMD_ERASE_OK) foreach (mem[i]) mem[i] = 16'hFFFF;
        else if (pend_e) sr[5] = 1'b1;
        {busy, sr[7], mode, pend_p, pend_e} = {32'd8, 1'b0, 2'd2, 2'b00};
      end else case (ld[7:0])
        `CMD_READ_ARRAY: mode = 2'd0;
        `CMD_READ_ID: mode = 2'd1;
        `CMD_READ_STATUS: mode = 2'd2;
        `CMD_CLEAR_STATUS: sr[5:3] = 3'h0;
        `CMD_PROGRAM: pend_p = 1'b1;
        `CMD_ERASE_SETUP: pend_e = 1'b1;
        default: ;
      endcase
    end
    wc_q = pins.we_n || pins.ce_n;
  end
endmodule

// *** testbench/flash_host_tb_top.sv ***
// Testbench for the flash host controller with a flash model.
// Assumes the design, package and checker are compiled first.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_host_tb_top;
  import flash_host_pkg::*;
  localparam logic [15:0] MFR = 16'h00A7; // Arbitrary value.
  localparam logic [15:0] DEV = 16'h3C5E; // Arbitrary value.
  logic        clk_sys, srst, vpp_ok, wp;
  axi_req_t    req;
  axi_rsp_t    rsp;
  flash_pins_t pins;
  logic [15:0] dq;
  logic [31:0] d;
  logic [1:0]  resp;
  int          errors = 0, tests_run = 0;
  flash_host uut (.clk_sys(clk_sys), .srst(srst), .axi_req(req), .axi_rsp(rsp), .pins(pins), .dq_in(dq),
    .write_protect(wp));
  boot_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.clk_sys(clk_sys), .pins(pins),
    .vpp_ok(vpp_ok), .dq_in(dq));
  // ==========================================
  // Clock and hang guard.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #1900000;
    hung();
  end
  task automatic results;
    $display("tests run %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic hung;
    errors++;
    results();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) errors++;
    if (seen !== exp) $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
  endtask
  // Bus cycles: the master holds each channel until taken.
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] w);
    int n;
    @(posedge clk_sys);
    req <= {1'b1, a, 1'b1, w, 4'hF, 1'b1, req.arvalid, req.araddr, req.rready};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && n < 99);
    req.bready <= 1'b0;
    resp = rsp.bresp;
    if (n >= 99) hung();
  endtask
  task automatic axi_rd(input logic [11:0] a);
    int n;
    @(posedge clk_sys);
    {req.arvalid, req.araddr, req.rready} <= {1'b1, a, 1'b1};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && n < 99);
    req.rready <= 1'b0;
    {resp, d} = {rsp.rresp, rsp.rdata};
    if (n >= 99) hung();
  endtask
  // One operation, wait until idle, fetch its read data.
  task automatic run(input op_t op, input logic [31:0] a);
    int n;
    axi_wr(`REG_ADDR, a);
    axi_wr(`REG_CTRL, {28'h0, op, 1'b1});
    n = 0;
    do begin
      axi_rd(`REG_STATUS);
      n++;
    end while (d[0] !== 1'b0 && n < 99);
    if (n >= 99) hung();
    axi_rd(`REG_RDATA);
  endtask
  task automatic prog(input logic [31:0] a, input logic [31:0] w, input logic [31:0] exp);
    int n;
    axi_wr(`REG_WDATA, w);
    run(OP_PROGRAM, a);
    n = 0;
    do begin
      run(OP_POLL, a);
      n++;
    end while (d[7] !== 1'b1 && n < 40);
    if (n >= 40) hung();
    check(d, exp);
  endtask
  // Main sequence.
  initial begin
    {req, srst, vpp_ok} = {65'h0, 2'b11};
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    run(OP_READ_ARRAY, 32'h2);
    check(d, 32'hFFFF);
    axi_rd(12'h0FC);
    check(resp, `RESP_SLVERR);
    check(d, 32'h0);
    axi_wr(12'h0F0, 32'h0);
    check(resp, 2'h2);
    for (int i = 0; i < 2; i++) begin
      run(OP_READ_ID, i);
      check(d, i ? DEV : MFR);
    end
    $display("test reset and identifier done");
    prog(32'h2, 32'h1234, 32'h80);
    run(OP_READ_STATUS, 32'h2);
    check(d, 32'h80);
    run(OP_READ_ARRAY, 32'h2);
    check(d, 32'h1234);
    $display("test program done");
    vpp_ok <= 1'b0;
    prog(32'h3, 32'h0, 32'h98);
    vpp_ok <= 1'b1;
    prog(32'h4, 32'h5555, 32'h98);
    run(OP_CLEAR, 32'h3);
    run(OP_READ_STATUS, 32'h3);
    check(d, 32'h80);
    run(OP_READ_ARRAY, 32'h3);
    check(d, 32'hFFFF);
    $display("test error flags done");
    run(OP_ERASE, 32'h9);
    run(OP_READ_ARRAY, 32'h4);
    check(d, 32'hFFFF);
    $display("test erase done");
    vpp_ok <= 1'b0;
    prog(32'h5, 32'h0, 32'h98);
    run(OP_RESET, 32'h6);
    run(OP_READ_ARRAY, 32'h6);
    check(d, 32'hFFFF);
    run(OP_READ_STATUS, 32'h6);
    check(d, 32'h80);
    axi_wr(`REG_CTRL, 32'h10);
    axi_rd(`REG_STATUS);
    check(d, 32'h4);
    check(pins.reset_powerdown_n, 1'b0);
    axi_rd(`REG_CTRL);
    check(d, 32'h14);
    axi_rd(`REG_ADDR);
    check(d, 32'h6);
    axi_wr(`REG_CTRL, 32'h0);
    run(OP_POLL, 32'h2);
    check(d, 32'hFFFF);
    $display("test pin reset done");
    results();
  end
endmodule
